// ---- src/mbsf_pkg.sv ----
// Package for the message buffer status flag bank.
// Assumes a plain register port with one-cycle read latency.
package mbsf_pkg;
    // Register map, word index times four
    localparam logic [7:0] CSR_BASE   = 8'h00;
    localparam logic [7:0] TYPE_BASE  = 8'h40;
    localparam logic [7:0] IRQ_STAT   = 8'h80;
    localparam logic [7:0] IRQ_CLR    = 8'h84;
    localparam logic [7:0] IRQ_EN     = 8'h88;
    // Field positions in buffer_control_status
    localparam int DUP_BIT  = 4;
    localparam int DATA_VALID_FLAG_BIT = 3;
    localparam int EDS_BIT  = 2;
    localparam int LOCK_STATUS_BIT = 1;
    localparam int IF_BIT   = 0;
    localparam int IE_BIT   = 8;
    localparam int LT_BIT   = 9;
    localparam int ET_BIT   = 10;
    // Buffer types
    localparam logic [1:0] TYPE_RX     = 2'h0;
    localparam logic [1:0] TYPE_TX_SGL = 2'h1;
    localparam logic [1:0] TYPE_TX_DBL = 2'h2;
    // Event types
    localparam int EVT_UPDATE = 0;
    localparam int EVT_ENABLE = 1;
    localparam logic [15:0] CSR_RESET = 16'h0000;
endpackage

// ---- src/mbsf_evt_if.sv ----
// Interface carrying per-buffer status update events.
// Assumes one driver, the status update logic.
`timescale 1ns/1ns
interface mbsf_evt_if #(parameter int NBUF = 8);
    logic [NBUF-1:0] slot_upd;
    logic [NBUF-1:0] empty_dyn;
    logic [NBUF-1:0] data_upd;
    logic [NBUF-1:0] data_ok;
    logic [NBUF-1:0] repeat_tx;
    logic [NBUF-1:0] commit_side;
    modport src (output slot_upd, empty_dyn, data_upd, data_ok, repeat_tx, commit_side);
    modport dst (input  slot_upd, empty_dyn, data_upd, data_ok, repeat_tx, commit_side);
endinterface

// ---- src/mbsf_buf.sv ----
// One buffer's status flags.
// Assumes write strobes are already decoded for this buffer.
`timescale 1ns/1ns
module mbsf_buf (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    // Control
    input  wire logic [1:0] type_in,
    input  wire logic       wr_in,
    input  wire logic [15:0] wdata_in,
    // Events
    input  wire logic       slot_upd_in,
    input  wire logic       empty_dyn_in,
    input  wire logic       data_upd_in,
    input  wire logic       data_ok_in,
    input  wire logic       repeat_in,
    input  wire logic       commit_in,
    input  wire logic       irq_clr_in,
    // Status
    output logic [15:0]     csr_out,
    output logic            irq_out
);
    logic data_updated_flag, data_valid_flag, enable_status, lock_status, iflag, ie;
    wire  is_rx    = (type_in == mbsf_pkg::TYPE_RX);
    wire  et_hit   = wr_in && wdata_in[mbsf_pkg::ET_BIT];
    wire  lt_hit   = wr_in && wdata_in[mbsf_pkg::LT_BIT] && !et_hit;
    wire  plain_wr = wr_in && !wdata_in[mbsf_pkg::ET_BIT] && !wdata_in[mbsf_pkg::LT_BIT];
    wire  en_event = et_hit && !enable_status && !is_rx;
    wire  set_if   = (slot_upd_in && (!is_rx || !empty_dyn_in)) || en_event;
    wire  clr_if   = (plain_wr && wdata_in[mbsf_pkg::IF_BIT]) || irq_clr_in;
    // Commit side only exists on a double transmit buffer
    wire  on_commit = commit_in && (type_in == mbsf_pkg::TYPE_TX_DBL);
    wire  next_data_valid_flag = is_rx ? data_ok_in : (on_commit ? 1'b0 : repeat_in);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_updated_flag   <= 1'b0;
            data_valid_flag  <= 1'b0;
            enable_status   <= 1'b0;
            lock_status  <= 1'b0;
            iflag <= 1'b0;
            ie    <= 1'b0;
        end else begin
            data_updated_flag   <= is_rx && data_upd_in;
            data_valid_flag  <= next_data_valid_flag;
            if (et_hit) enable_status <= !enable_status;
            if (lt_hit) lock_status <= !lock_status;
            if (plain_wr) ie <= wdata_in[mbsf_pkg::IE_BIT];
            // Set beats clear when they coincide
            iflag <= set_if | (iflag & ~clr_if);
        end
    end

    assign csr_out = {7'h00, ie, 3'h0, data_updated_flag, data_valid_flag, enable_status, lock_status, iflag};
    assign irq_out = ie && iflag;
endmodule // mbsf_buf

// ---- src/mbsf_top.sv ----
// Status flag bank for a set of message buffers.
// Assumes synchronous inputs and a master that never waits.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mbsf_top #(
    parameter int NBUF = 8
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             nrst_in,
    // Register port
    input  wire logic [7:0]       addr_in,
    input  wire logic [15:0]      wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic [15:0]           rdata_out,
    // Status update events
    input  wire logic [NBUF-1:0]  slot_upd_in,
    input  wire logic [NBUF-1:0]  empty_dyn_in,
    input  wire logic [NBUF-1:0]  data_upd_in,
    input  wire logic [NBUF-1:0]  data_ok_in,
    input  wire logic [NBUF-1:0]  repeat_in,
    input  wire logic [NBUF-1:0]  commit_in,
    // Interrupt
    output logic                  irq_out
);
    mbsf_evt_if #(.NBUF(NBUF)) evt ();
    assign evt.slot_upd    = slot_upd_in;
    assign evt.empty_dyn   = empty_dyn_in;
    assign evt.data_upd    = data_upd_in;
    assign evt.data_ok     = data_ok_in;
    assign evt.repeat_tx   = repeat_in;
    assign evt.commit_side = commit_in;

    logic [15:0]     csr   [NBUF];
    logic [1:0]      btype [NBUF];
    logic [NBUF-1:0] birq, stat, ien;

    wire [5:0] idx    = addr_in[7:2];
    wire [5:0] tidx   = idx - 6'd16;
    wire       in_csr = (addr_in < mbsf_pkg::TYPE_BASE);
    wire       in_typ = (addr_in >= mbsf_pkg::TYPE_BASE) && (addr_in < mbsf_pkg::IRQ_STAT);
    wire       clr_wr = wr_in && (addr_in == mbsf_pkg::IRQ_CLR);

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NBUF; g++) begin : gb
            wire csr_wr = wr_in && in_csr && (idx == 6'(g));
            wire typ_wr = wr_in && in_typ && (idx == 6'(g + 16));
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) btype[g] <= mbsf_pkg::TYPE_RX;
                else if (typ_wr) btype[g] <= wdata_in[1:0];
            end
            mbsf_buf u_buf (
                .ref_clk_in   (ref_clk_in),
                .nrst_in      (nrst_in),
                .type_in      (btype[g]),
                .wr_in        (csr_wr),
                .wdata_in     (wdata_in),
                .slot_upd_in  (evt.slot_upd[g]),
                .empty_dyn_in (evt.empty_dyn[g]),
                .data_upd_in  (evt.data_upd[g]),
                .data_ok_in   (evt.data_ok[g]),
                .repeat_in    (evt.repeat_tx[g]),
                .commit_in    (evt.commit_side[g]),
                .irq_clr_in   (clr_wr && wdata_in[g]),
                .csr_out      (csr[g]),
                .irq_out      (birq[g])
            );
            assign stat[g] = csr[g][mbsf_pkg::IF_BIT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (in_csr && idx < 6'(NBUF)) rd_mux = csr[idx[$clog2(NBUF)-1:0]];
        else if (in_typ && tidx < 6'(NBUF)) rd_mux = {14'h0000, btype[tidx[$clog2(NBUF)-1:0]]};
        else if (addr_in == mbsf_pkg::IRQ_STAT) rd_mux = 16'(stat);
        else if (addr_in == mbsf_pkg::IRQ_EN) rd_mux = 16'(ien);
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 16'h0000;
            ien       <= '1;
            irq_out   <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rd_mux : 16'h0000;
            if (wr_in && addr_in == mbsf_pkg::IRQ_EN) ien <= wdata_in[NBUF-1:0];
            irq_out   <= |(birq & ien);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_irq;
        @(posedge ref_clk_in) disable iff (!nrst_in) (|(birq & ien)) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
    property p_noirq;
        @(posedge ref_clk_in) disable iff (!nrst_in) !(|(birq & ien)) |=> !irq_out;
    endproperty
    a_noirq: assert property (p_noirq) else $error("spurious irq");
    property p_dup_tx;
        @(posedge ref_clk_in) disable iff (!nrst_in) (btype[1] != mbsf_pkg::TYPE_RX) |=> !csr[1][4];
    endproperty
    a_dup_tx: assert property (p_dup_tx) else $error("dup set on tx");
    property p_dup_rx;
        @(posedge ref_clk_in) disable iff (!nrst_in) (btype[0] == mbsf_pkg::TYPE_RX && data_upd_in[0]) |=> csr[0][4];
    endproperty
    a_dup_rx: assert property (p_dup_rx) else $error("dup missed");
    property p_data_valid_flag_rx;
        @(posedge ref_clk_in) disable iff (!nrst_in) (btype[0] == mbsf_pkg::TYPE_RX) |=> csr[0][3] == $past(data_ok_in[0]);
    endproperty
    a_data_valid_flag_rx: assert property (p_data_valid_flag_rx) else $error("data_valid_flag wrong rx");
    property p_data_valid_flag_cm;
        @(posedge ref_clk_in) disable iff (!nrst_in) (btype[0] == mbsf_pkg::TYPE_TX_DBL && commit_in[0]) |=> !csr[0][3];
    endproperty
    a_data_valid_flag_cm: assert property (p_data_valid_flag_cm) else $error("data_valid_flag commit");
    property p_set;
        @(posedge ref_clk_in) disable iff (!nrst_in) (slot_upd_in[0] && !empty_dyn_in[0]) |=> csr[0][0];
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_empty;
        @(posedge ref_clk_in) disable iff (!nrst_in)
            (btype[0] == mbsf_pkg::TYPE_RX && !csr[0][0] && !wr_in && slot_upd_in[0] && empty_dyn_in[0]) |=> !csr[0][0];
    endproperty
    a_empty: assert property (p_empty) else $error("flag on empty slot");
    property p_clr;
        @(posedge ref_clk_in) disable iff (!nrst_in)
            (wr_in && addr_in == mbsf_pkg::IRQ_CLR && wdata_in[0] && !slot_upd_in[0]) |=> !csr[0][0];
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_tog;
        @(posedge ref_clk_in) disable iff (!nrst_in)
            (wr_in && addr_in == mbsf_pkg::CSR_BASE && wdata_in[10]) |=> csr[0][2] != $past(csr[0][2]);
    endproperty
    a_tog: assert property (p_tog) else $error("enable no toggle");
endmodule // mbsf_top

// ---- test/tb_top.sv ----
// Self-checking bench for the message buffer status flag bank.
// Assumes mbsf_top with its register port and event inputs; reads checked through a queue.
`timescale 1ns/1ns
module tb_top;
    localparam int NB = 4;
    logic            ref_clk_in;
    logic            nrst_in;
    logic [7:0]      addr_in;
    logic [15:0]     wdata_in;
    logic            wr_in;
    logic            rd_in;
    logic [15:0]     rdata_out;
    logic [NB-1:0]   slot_upd_in;
    logic [NB-1:0]   empty_dyn_in;
    logic [NB-1:0]   data_upd_in;
    logic [NB-1:0]   data_ok_in;
    logic [NB-1:0]   repeat_in;
    logic [NB-1:0]   commit_in;
    logic            irq_out;
    logic [15:0]     exp_q[$];
    logic [15:0]     e;
    logic            rd_d;
    logic [31:0]     v;
    int              bad_count;
    int              checked;
    int              cyc;

    mbsf_top #(.NBUF(NB)) DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .slot_upd_in(slot_upd_in), .empty_dyn_in(empty_dyn_in), .data_upd_in(data_upd_in),
        .data_ok_in(data_ok_in), .repeat_in(repeat_in), .commit_in(commit_in), .irq_out(irq_out));

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] ex, input logic [15:0] got);
        checked++;
        if (got !== ex) begin
            $display("MISMATCH %s expected %h seen %h", name, ex, got);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] ex);
        @(posedge ref_clk_in);
        rd_in <= 1'b1; addr_in <= a;
        exp_q.push_back(ex);
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
    endtask
    // Event inputs hold for one edge, then two more edges pass so the one-cycle status latency is covered
    task automatic slot(input int b, input logic emp);
        @(posedge ref_clk_in);
        slot_upd_in[b] <= 1'b1; empty_dyn_in[b] <= emp;
        @(posedge ref_clk_in);
        slot_upd_in[b] <= 1'b0; empty_dyn_in[b] <= 1'b0;
        tick(2);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk_in) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            chk("rdata", e, rdata_out);
        end
        rd_d <= rd_in;
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_in = 1'b0; addr_in = 8'h00; wdata_in = 16'h0000; wr_in = 1'b0; rd_in = 1'b0; rd_d = 1'b0;
        slot_upd_in = '0; empty_dyn_in = '0; data_upd_in = '0; data_ok_in = '0; repeat_in = '0; commit_in = '0;
        bad_count = 0; checked = 0; cyc = 0;
        v = $urandom(22);
        tick(8);
        nrst_in <= 1'b1;
        rd(8'h00, 16'h0000);
        rd(mbsf_pkg::IRQ_EN, 16'h000F);
        rd(8'hFC, 16'h0000);
        // Receive buffer 0
        data_upd_in[0] <= 1'b1; data_ok_in[0] <= 1'b1; tick(2);
        rd(8'h00, 16'h0018);
        data_upd_in[0] <= 1'b0; tick(2);
        rd(8'h00, 16'h0008);
        slot(0, 1'b1);
        rd(8'h00, 16'h0008);
        slot(0, 1'b0);
        rd(8'h00, 16'h0009);
        wr(8'h00, 16'h001E);
        rd(8'h00, 16'h0009);
        wr(8'h00, 16'h0001);
        rd(8'h00, 16'h0008);
        wr(8'h00, 16'h0400);
        rd(8'h00, 16'h000C);
        wr(8'h00, 16'h0200);
        rd(8'h00, 16'h000E);
        wr(8'h00, 16'h0600);
        rd(8'h00, 16'h000A);
        wr(8'h00, 16'h0200);
        rd(8'h00, 16'h0008);
        // Single transmit buffer 1
        wr(mbsf_pkg::TYPE_BASE + 8'h04, 16'h0001);
        data_upd_in[1] <= 1'b1; data_ok_in[1] <= 1'b1; tick(2);
        rd(8'h04, 16'h0000);
        repeat_in[1] <= 1'b1; tick(2);
        rd(8'h04, 16'h0008);
        wr(8'h04, 16'h0400);
        rd(8'h04, 16'h000D);
        wr(8'h04, 16'h0101);
        rd(8'h04, 16'h010C);
        slot(1, 1'b0);
        rd(8'h04, 16'h010D);
        rd(mbsf_pkg::IRQ_STAT, 16'h0002);
        tick(2);
        chk("irq", 16'h0001, {15'h0000, irq_out});
        wr(mbsf_pkg::IRQ_EN, 16'h0000);
        tick(2);
        chk("irq", 16'h0000, {15'h0000, irq_out});
        wr(mbsf_pkg::IRQ_EN, 16'h000F);
        wr(8'h04, 16'h0000);
        tick(2);
        chk("irq", 16'h0000, {15'h0000, irq_out});
        wr(mbsf_pkg::IRQ_CLR, 16'h0002);
        rd(8'h04, 16'h000C);
        // Double transmit buffer 2
        wr(mbsf_pkg::TYPE_BASE + 8'h08, 16'h0002);
        commit_in[2] <= 1'b1; repeat_in[2] <= 1'b1; tick(2);
        rd(8'h08, 16'h0000);
        commit_in[2] <= 1'b0; tick(2);
        rd(8'h08, 16'h0008);
        // Random levels on receive buffer 3
        repeat (8) begin
            v = $urandom();
            data_upd_in[3] <= v[0]; data_ok_in[3] <= v[1]; tick(2);
            rd(8'h0C, {11'h000, v[0], v[1], 3'h0});
        end
        tick(4);
        results();
    end
endmodule // tb_top
